// ===== hdl/aas_defs.vh
// Constants for the alarm annunciator sequencer.
// Assumes inclusion by bare name from hdl/; no other dependency.
// Operation
// - Exactly one of five flash/reset patterns applies to all channel indications; mode-2 channels here ignore it and light steady.
// - Pattern codes: 0 auto, 1 auto+manual audible, 2 manual, 3 ringback, 4 ringback.
// - Pattern is unit-wide for 16 channels, held in channel-0 parameter register.
// - Each channel has a three-valued mode; 0 means plain unit pattern.
// - Mode 1 adds audible ringback when the channel returns to normal.
// - Mode 2: steady light on transition, auto clear on normal, no audible.
// - Trips follow alarm sequences but flash at double the alarm rate.
// - First alarm or trip after reset is latched; later events ignored.
// - First-out display: channel in right two digits, type in left two.
// - Type codes: single low, single high, double low, double high symbols.
// - Unmanned-station input active suppresses audible alarm output.
// - Maintenance input active blocks group realarm outputs.
// - Neither input active: audible and group realarm delivered normally.
// - Control-site mode over bus: 1 inputs, 2 maintenance, 3 unmanned.
// - Clock resynchronizes once a second from the bus sync pulse.
// - Minute-sync input rounds clock to nearest whole minute.
// - Sync acts at closing instant; party holds pulse at least 100 ms.
// - Time-of-day counter gives year, month, day, hour, minute, second.
// - Raw reading returned as unscaled binary 0 to 1023.
// - Contact channel reads 0 open, 1 closed; analogue reads scaled value.
// - Each channel stores a 10-character text writable by software.
// - Audible operates on any set-point crossing except mode-2 channels; sounds here only when none of the channel's four inputs was already active.
`ifndef AAS_DEFS_VH
`define AAS_DEFS_VH

`define AAS_NCH            16
// Register map, word offsets on the plain port
`define AAS_A_PATTERN      8'h00
`define AAS_A_SITE         8'h01
`define AAS_A_FLASHDIV     8'h02
`define AAS_A_FIRSTOUT     8'h03
`define AAS_A_STATUS       8'h04
`define AAS_A_TIME_HI      8'h05
`define AAS_A_TIME_LO      8'h06
`define AAS_A_CMD          8'h07
`define AAS_A_CHMODE       8'h10
`define AAS_A_RAW          8'h20
`define AAS_A_SCALED       8'h30
`define AAS_A_TEXT         8'h40
// Pattern codes
`define AAS_PAT_AUTO       3'd0
`define AAS_PAT_AUTO_MA    3'd1
`define AAS_PAT_MANUAL     3'd2
`define AAS_PAT_RING       3'd3
`define AAS_PAT_RING_D     3'd4
// Channel indication modes
`define AAS_CM_PLAIN       2'd0
`define AAS_CM_RINGAUD     2'd1
`define AAS_CM_STEADY      2'd2
// Control-site modes
`define AAS_SITE_INPUTS    2'd1
`define AAS_SITE_MAINT     2'd2
`define AAS_SITE_UNMAN     2'd3
// First-out type codes (left digits)
`define AAS_FO_LO          8'h0a
`define AAS_FO_HI          8'h0b
`define AAS_FO_LOLO        8'haa
`define AAS_FO_HIHI        8'hbb
// Command bits
`define AAS_CMD_ACK        0
`define AAS_CMD_RESET      1
`define AAS_CMD_SECSYNC    2
// Reset values
`define AAS_FLASHDIV_RST   24'd12500000
`define AAS_SITE_RST       2'd1
// Timing
`define AAS_CLK_MHZ        100
`define AAS_SYNC_MIN_MS    100
`define AAS_CYC_PER_SEC    (`AAS_CLK_MHZ * 1000000)

`endif

// ===== hdl/aas_sequencer.v
// Alarm annunciator sequencer: per-channel flash/reset sequence, first-out,
// site-mode gating, time-of-day clock and register port.
// Assumes field events are already set-point crossings on clk_sys (synchronised
// here), raw readings come from an external converter on clk_sys.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "aas_defs.vh"

module aas_sequencer #(
	parameter NCH        = 16,
	parameter SEC_CYCLES = `AAS_CYC_PER_SEC
) (
	input  wire             clk_sys,
	input  wire             rst_n,
	input  wire             clk_en,
	input  wire [NCH-1:0]   alarm_lo_in,
	input  wire [NCH-1:0]   alarm_hi_in,
	input  wire [NCH-1:0]   trip_lo_in,
	input  wire [NCH-1:0]   trip_hi_in,
	input  wire [NCH-1:0]   contact_type,
	input  wire [NCH*10-1:0] raw_reading,
	input  wire [NCH*16-1:0] scaled_reading,
	input  wire             ack_in,
	input  wire             reset_in,
	input  wire             local_in,
	input  wire             remote_in,
	input  wire             minute_sync_in,
	input  wire             bus_sync_in,
	input  wire [7:0]       reg_addr,
	input  wire [31:0]      reg_wdata,
	input  wire             reg_wr,
	input  wire             reg_rd,
	output reg  [31:0]      reg_rdata,
	output reg  [NCH-1:0]   lamp_out,
	output reg              audible_out,
	output reg              group_realarm_out,
	output reg  [15:0]      first_out_disp
);

	localparam ST_IDLE = 5'b00001;
	localparam ST_FLASH = 5'b00010;
	localparam ST_ACKED = 5'b00100;
	localparam ST_RING = 5'b01000;
	localparam ST_STEADY = 5'b10000;
	localparam [7:0] YR_RST = 8'd0;

	// Two-flop synchronisers for all field inputs
	localparam NS = 4*NCH + 5;
	wire [NS-1:0] pin_raw = {alarm_lo_in, alarm_hi_in, trip_lo_in, trip_hi_in,
		ack_in, reset_in, local_in, remote_in, minute_sync_in};
	reg  [NS-1:0] sync1_reg;
	reg  [NS-1:0] sync2_reg;
	reg           bus_s1_reg;
	reg           bus_s2_reg;
	reg           bus_prev_reg;
	reg           msync_prev_reg;
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= {NS{1'b0}};
			sync2_reg <= {NS{1'b0}};
			bus_s1_reg <= 1'b0;
			bus_s2_reg <= 1'b0;
		end else if (clk_en) begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
			bus_s1_reg <= bus_sync_in;
			bus_s2_reg <= bus_s1_reg;
		end
	end
	wire [NCH-1:0] a_lo = sync2_reg[NS-1 -: NCH];
	wire [NCH-1:0] a_hi = sync2_reg[NS-1-NCH -: NCH];
	wire [NCH-1:0] t_lo = sync2_reg[NS-1-2*NCH -: NCH];
	wire [NCH-1:0] t_hi = sync2_reg[NS-1-3*NCH -: NCH];
	wire ack_s = sync2_reg[4];
	wire rst_s = sync2_reg[3];
	wire local_s = sync2_reg[2];
	wire remote_s = sync2_reg[1];
	wire msync_s = sync2_reg[0];

	// Registers
	reg  [2:0]     pattern_reg;
	reg  [1:0]     site_reg;
	reg  [23:0]    flashdiv_reg;
	reg  [2*NCH-1:0] chmode_reg;
	reg  [7:0]     text_mem [0:NCH*10-1];
	reg  [2:0]     cmd_reg;
	wire wr_cmd = reg_wr && reg_addr == `AAS_A_CMD;

	// Flash divider: trip toggles every count, alarm every second toggle of trip
	reg  [23:0] fdiv_cnt_reg;
	reg         trip_flash_reg;
	reg         alarm_flash_reg;
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fdiv_cnt_reg <= 24'd0;
			trip_flash_reg <= 1'b0;
			alarm_flash_reg <= 1'b0;
		end else if (clk_en) begin
			if (fdiv_cnt_reg >= flashdiv_reg) begin
				fdiv_cnt_reg <= 24'd0;
				trip_flash_reg <= ~trip_flash_reg;
				if (trip_flash_reg)
					alarm_flash_reg <= ~alarm_flash_reg;
			end else begin
				fdiv_cnt_reg <= fdiv_cnt_reg + 24'd1;
			end
		end
	end

	// Operator events: pins or register command
	wire op_ack = ack_s | (wr_cmd & reg_wdata[`AAS_CMD_ACK]);
	wire op_reset = rst_s | (wr_cmd & reg_wdata[`AAS_CMD_RESET]);
	wire auto_rst = pattern_reg == `AAS_PAT_AUTO || pattern_reg == `AAS_PAT_AUTO_MA;
	wire ringback = pattern_reg == `AAS_PAT_RING || pattern_reg == `AAS_PAT_RING_D;
	wire man_audible = pattern_reg != `AAS_PAT_AUTO;

	// Per-channel sequence state
	reg  [4:0]     st_reg [0:NCH-1];
	reg  [NCH-1:0] trip_ev_reg;
	reg  [NCH-1:0] horn_req_reg;
	reg  [NCH-1:0] prev_act_reg;
	wire [NCH-1:0] act = a_lo | a_hi | t_lo | t_hi;
	wire [NCH-1:0] tr = t_lo | t_hi;
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : g_ch
			wire [1:0] cm = chmode_reg[2*g +: 2];
			wire rise = act[g] & ~prev_act_reg[g];
			wire fall = ~act[g] & prev_act_reg[g];
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					st_reg[g] <= ST_IDLE;
					trip_ev_reg[g] <= 1'b0;
					horn_req_reg[g] <= 1'b0;
					prev_act_reg[g] <= 1'b0;
					lamp_out[g] <= 1'b0;
				end else if (clk_en) begin
					prev_act_reg[g] <= act[g];
					if (rise && cm != `AAS_CM_STEADY)
						horn_req_reg[g] <= 1'b1;
					else if (fall && cm == `AAS_CM_RINGAUD && ringback)
						horn_req_reg[g] <= 1'b1;
					else if ((man_audible && op_ack) || (!man_audible && !act[g]))
						horn_req_reg[g] <= 1'b0;
					if (rise)
						trip_ev_reg[g] <= tr[g];
					case (st_reg[g])
						ST_IDLE: begin
							if (rise)
								st_reg[g] <= (cm == `AAS_CM_STEADY) ? ST_STEADY : ST_FLASH;
						end
						ST_STEADY: begin
							if (!act[g])
								st_reg[g] <= ST_IDLE;
						end
						ST_FLASH: begin
							if (auto_rst && !act[g])
								st_reg[g] <= ST_IDLE;
							else if (op_ack)
								st_reg[g] <= ST_ACKED;
						end
						ST_ACKED: begin
							if (rise)
								st_reg[g] <= ST_FLASH;
							else if (!act[g] && auto_rst)
								st_reg[g] <= ST_IDLE;
							else if (!act[g] && ringback)
								st_reg[g] <= ST_RING;
							else if (!act[g] && op_reset)
								st_reg[g] <= ST_IDLE;
						end
						ST_RING: begin
							if (rise)
								st_reg[g] <= ST_FLASH;
							else if (op_reset)
								st_reg[g] <= ST_IDLE;
						end
						default: st_reg[g] <= ST_IDLE;
					endcase
					case (st_reg[g])
						ST_FLASH: lamp_out[g] <= trip_ev_reg[g] ? trip_flash_reg
							: alarm_flash_reg;
						ST_RING: lamp_out[g] <= alarm_flash_reg;
						ST_ACKED, ST_STEADY: lamp_out[g] <= 1'b1;
						default: lamp_out[g] <= 1'b0;
					endcase
				end
			end
		end
	endgenerate

	// First-out latch: lowest channel wins when several rise together
	reg        fo_valid_reg;
	integer i;
	reg        fo_hit;
	reg  [7:0] fo_type;
	reg  [7:0] fo_ch;
	always @* begin
		fo_hit = 1'b0;
		fo_type = 8'h00;
		fo_ch = 8'h00;
		for (i = NCH - 1; i >= 0; i = i - 1) begin
			if (act[i] && !prev_act_reg[i]) begin
				fo_hit = 1'b1;
				fo_ch = i[7:0] + 8'd1;
				fo_type = t_hi[i] ? `AAS_FO_HIHI : t_lo[i] ? `AAS_FO_LOLO :
					a_hi[i] ? `AAS_FO_HI : `AAS_FO_LO;
			end
		end
	end
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fo_valid_reg <= 1'b0;
			first_out_disp <= 16'h0000;
		end else if (clk_en) begin
			if (op_reset) begin
				fo_valid_reg <= 1'b0;
				first_out_disp <= 16'h0000;
			end else if (fo_hit && !fo_valid_reg) begin
				fo_valid_reg <= 1'b1;
				first_out_disp <= {fo_type, fo_ch};
			end
		end
	end

	// Site-mode gating of audible and group realarm
	wire maint = (site_reg == `AAS_SITE_MAINT) || (site_reg == `AAS_SITE_INPUTS && local_s);
	wire unman = (site_reg == `AAS_SITE_UNMAN) || (site_reg == `AAS_SITE_INPUTS && remote_s);
	reg  [NCH-1:0] flash_any;
	integer k;
	always @* begin
		for (k = 0; k < NCH; k = k + 1)
			flash_any[k] = st_reg[k] == ST_FLASH;
	end
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			audible_out <= 1'b0;
			group_realarm_out <= 1'b0;
		end else if (clk_en) begin
			audible_out <= |horn_req_reg & ~unman;
			group_realarm_out <= |flash_any & ~maint;
		end
	end

	// Time of day; bus pulse aligns seconds, minute sync rounds minute
	reg  [31:0] subsec_reg;
	reg  [5:0]  sec_reg;
	reg  [5:0]  min_reg;
	reg  [4:0]  hour_reg;
	reg  [4:0]  day_reg;
	reg  [3:0]  mon_reg;
	reg  [7:0]  year_reg;
	wire bus_pulse = (bus_s2_reg & ~bus_prev_reg) | (wr_cmd & reg_wdata[`AAS_CMD_SECSYNC]);
	wire msync_pulse = msync_s & ~msync_prev_reg;
	wire sec_tick = subsec_reg == SEC_CYCLES - 1;
	wire round_up = sec_reg >= 6'd30;
	wire min_carry = (sec_tick && sec_reg == 6'd59) || (msync_pulse && round_up);
	wire hr_carry = min_carry && min_reg == 6'd59;
	wire day_carry = hr_carry && hour_reg == 5'd23;
	wire mon_carry = day_carry && day_reg == 5'd31;
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bus_prev_reg <= 1'b0;
			msync_prev_reg <= 1'b0;
			subsec_reg <= 32'd0;
			sec_reg <= 6'd0;
			min_reg <= 6'd0;
			hour_reg <= 5'd0;
			day_reg <= 5'd1;
			mon_reg <= 4'd1;
			year_reg <= YR_RST;
		end else if (clk_en) begin
			bus_prev_reg <= bus_s2_reg;
			msync_prev_reg <= msync_s;
			if (msync_pulse) begin
				subsec_reg <= 32'd0;
				sec_reg <= 6'd0;
			end else if (bus_pulse) begin
				subsec_reg <= 32'd0;
			end else if (sec_tick) begin
				subsec_reg <= 32'd0;
				sec_reg <= (sec_reg == 6'd59) ? 6'd0 : sec_reg + 6'd1;
			end else begin
				subsec_reg <= subsec_reg + 32'd1;
			end
			if (min_carry)
				min_reg <= (min_reg == 6'd59) ? 6'd0 : min_reg + 6'd1;
			if (hr_carry)
				hour_reg <= (hour_reg == 5'd23) ? 5'd0 : hour_reg + 5'd1;
			if (day_carry)
				day_reg <= mon_carry ? 5'd1 : day_reg + 5'd1;
			if (mon_carry)
				mon_reg <= (mon_reg == 4'd12) ? 4'd1 : mon_reg + 4'd1;
			if (mon_carry && mon_reg == 4'd12)
				year_reg <= year_reg + 8'd1;
			if (reg_wr && reg_addr == `AAS_A_TIME_HI) begin
				year_reg <= reg_wdata[23:16];
				mon_reg <= reg_wdata[11:8];
				day_reg <= reg_wdata[4:0];
			end
			if (reg_wr && reg_addr == `AAS_A_TIME_LO) begin
				hour_reg <= reg_wdata[20:16];
				min_reg <= reg_wdata[13:8];
				sec_reg <= reg_wdata[5:0];
				subsec_reg <= 32'd0;
			end
		end
	end

	// Register writes
	integer c;
	wire [3:0] ch_idx = reg_addr[3:0];
	wire [3:0] txt_ch = reg_addr[5:2];
	wire [1:0] txt_wd = reg_addr[1:0];
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pattern_reg <= `AAS_PAT_AUTO;
			site_reg <= `AAS_SITE_RST;
			flashdiv_reg <= `AAS_FLASHDIV_RST;
			chmode_reg <= {2*NCH{1'b0}};
		end else if (clk_en && reg_wr) begin
			if (reg_addr == `AAS_A_PATTERN && reg_wdata[2:0] <= `AAS_PAT_RING_D)
				pattern_reg <= reg_wdata[2:0];
			if (reg_addr == `AAS_A_SITE && reg_wdata[1:0] != 2'd0)
				site_reg <= reg_wdata[1:0];
			if (reg_addr == `AAS_A_FLASHDIV)
				flashdiv_reg <= reg_wdata[23:0];
			if (reg_addr[7:4] == 4'h1 && reg_wdata[1:0] != 2'd3)
				chmode_reg[2*ch_idx +: 2] <= reg_wdata[1:0];
		end
	end
	// Text: 3 words per channel at 0x40 + ch*4, bytes low first, 10 kept
	always @(posedge clk_sys) begin
		if (clk_en && reg_wr && reg_addr[7:6] == 2'b01 && txt_wd != 2'd3) begin
			for (c = 0; c < 4; c = c + 1)
				if (txt_wd * 4 + c < 10)
					text_mem[txt_ch * 10 + txt_wd * 4 + c] <= reg_wdata[8*c +: 8];
		end
	end

	// Register reads, data in the following cycle
	reg  [31:0] rd_next;
	integer b;
	always @* begin
		rd_next = 32'h0000_0000;
		case (reg_addr[7:4])
			4'h0: begin
				case (reg_addr)
					`AAS_A_PATTERN: rd_next = {29'd0, pattern_reg};
					`AAS_A_SITE: rd_next = {30'd0, site_reg};
					`AAS_A_FLASHDIV: rd_next = {8'd0, flashdiv_reg};
					`AAS_A_FIRSTOUT: rd_next = {15'd0, fo_valid_reg, first_out_disp};
					`AAS_A_STATUS: rd_next = {14'd0, unman, maint, lamp_out};
					`AAS_A_TIME_HI: rd_next = {8'd0, year_reg, 4'd0, mon_reg, 3'd0, day_reg};
					`AAS_A_TIME_LO: rd_next = {11'd0, hour_reg, 2'd0, min_reg, 2'd0, sec_reg};
					default: rd_next = 32'h0000_0000;
				endcase
			end
			4'h1: rd_next = {30'd0, chmode_reg[2*ch_idx +: 2]};
			4'h2: rd_next = {22'd0, raw_reading[10*ch_idx +: 10]};
			4'h3: rd_next = contact_type[ch_idx] ? {31'd0, act[ch_idx]}
				: {16'd0, scaled_reading[16*ch_idx +: 16]};
			4'h4, 4'h5, 4'h6, 4'h7: begin
				for (b = 0; b < 4; b = b + 1)
					if (txt_wd * 4 + b < 10)
						rd_next[8*b +: 8] = text_mem[txt_ch * 10 + txt_wd * 4 + b];
			end
			default: rd_next = 32'h0000_0000;
		endcase
	end
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 32'h0000_0000;
		else if (clk_en && reg_rd)
			reg_rdata <= rd_next;
		else if (clk_en)
			reg_rdata <= 32'h0000_0000;
	end

endmodule // aas_sequencer
`default_nettype wire

// ===== verification/aas_field_model.sv
// Field side model: converter readings and the two sync contacts.
// Assumes the bench calls its tasks; all changes land after clk_sys edges.
`timescale 1ns/1ps
`default_nettype none
module aas_field_model #(
	parameter HOLD = 10
) (
	input wire logic       clk_sys,
	output logic [159:0]   raw_reading,
	output logic [255:0]   scaled_reading,
	output logic [15:0]    contact_type,
	output logic           minute_sync_in,
	output logic           bus_sync_in
);
	initial begin
		raw_reading = '0;
		scaled_reading = '0;
		contact_type = 16'h00ff;
		minute_sync_in = 1'b0;
		bus_sync_in = 1'b0;
	end
	task set_raw(input int ch, input logic [9:0] v);
		@(posedge clk_sys);
		raw_reading[ch*10 +: 10] <= v;
		scaled_reading[ch*16 +: 16] <= {6'h0, v};
	endtask
	// HOLD is the minimum contact time scaled to the shortened second
	task sync_pulse(input logic minute);
		@(posedge clk_sys);
		if (minute) minute_sync_in <= 1'b1;
		else bus_sync_in <= 1'b1;
		repeat (HOLD) @(posedge clk_sys);
		minute_sync_in <= 1'b0;
		bus_sync_in <= 1'b0;
	endtask
endmodule // aas_field_model
`default_nettype wire

// ===== verification/aas_seq_monitor.sv
// Checker on the sequencer ports: read port, site gating, first-out display.
// Assumes one clock domain and the register map of aas_defs.vh.
`timescale 1ns/1ps
`default_nettype none
module aas_seq_monitor #(
	parameter NCH = 16
) (
	input wire logic             clk_sys,
	input wire logic             rst_n,
	input wire logic             clk_en,
	input wire logic [NCH-1:0]   alarm_lo_in,
	input wire logic [NCH-1:0]   alarm_hi_in,
	input wire logic [NCH-1:0]   trip_lo_in,
	input wire logic [NCH-1:0]   trip_hi_in,
	input wire logic [NCH*10-1:0] raw_reading,
	input wire logic             reset_in,
	input wire logic             local_in,
	input wire logic             remote_in,
	input wire logic [7:0]       reg_addr,
	input wire logic [31:0]      reg_wdata,
	input wire logic             reg_wr,
	input wire logic             reg_rd,
	input wire logic [31:0]      reg_rdata,
	input wire logic             audible_out,
	input wire logic             group_realarm_out,
	input wire logic [15:0]      first_out_disp
);
	logic [1:0]       site_h;
	logic [3:0]       una_cnt, mnt_cnt, ev_cnt, q_cnt;
	logic [4*NCH-1:0] fld_d;
	wire  [4*NCH-1:0] fld = {alarm_lo_in, alarm_hi_in, trip_lo_in, trip_hi_in};
	wire              una = site_h == 2'h3 || (site_h == 2'h1 && remote_in);
	wire              mnt = site_h == 2'h2 || (site_h == 2'h1 && local_in);
	// Any cause that may legally move audible or first-out restarts this count
	wire              cause = fld != fld_d || reset_in || reg_wr || remote_in || local_in;
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			site_h <= 2'h1;
			una_cnt <= 4'h0;
			mnt_cnt <= 4'h0;
			ev_cnt <= 4'h0;
			q_cnt <= 4'h0;
			fld_d <= '0;
		end else begin
			if (clk_en && reg_wr && reg_addr == 8'h01 && reg_wdata[1:0] != 2'h0)
				site_h <= reg_wdata[1:0];
			una_cnt <= una ? una_cnt + {3'h0, una_cnt != 4'hf} : 4'h0;
			mnt_cnt <= mnt ? mnt_cnt + {3'h0, mnt_cnt != 4'hf} : 4'h0;
			ev_cnt <= cause ? 4'h0 : ev_cnt + {3'h0, ev_cnt != 4'hf};
			q_cnt <= (reset_in || reg_wr) ? 4'h0 : q_cnt + {3'h0, q_cnt != 4'hf};
			fld_d <= fld;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	chk_rdata_idle: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside a read");
	chk_unmapped_zero: assert property (clk_en && reg_rd && reg_addr == 8'h08 |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	chk_site_read: assert property (
		clk_en && reg_rd && reg_addr == 8'h01 |=> reg_rdata == {30'h0, site_h})
		else $error("site mode read wrong");
	chk_raw_read: assert property (
		clk_en && reg_rd && reg_addr[7:4] == 4'h2 |=>
		reg_rdata == (($past(raw_reading) >> ($past(reg_addr[3:0]) * 10)) & 32'h3ff))
		else $error("raw reading read wrong");
	chk_unman_mute: assert property (una_cnt > 4'd5 |-> !audible_out)
		else $error("audible active in unmanned mode");
	chk_maint_block: assert property (mnt_cnt > 4'd5 |-> !group_realarm_out)
		else $error("group realarm active in maintenance mode");
	chk_fo_codes: assert property (first_out_disp != 16'h0 |->
		first_out_disp[15:8] inside {8'h0a, 8'h0b, 8'haa, 8'hbb} &&
		first_out_disp[7:0] inside {[8'h01:8'h10]})
		else $error("first-out display code out of range");
	chk_fo_hold: assert property (
		$past(first_out_disp) != 16'h0 && $changed(first_out_disp) |-> q_cnt < 4'd8)
		else $error("first-out changed without reset");
	chk_fo_cause: assert property (
		$past(first_out_disp) == 16'h0 && first_out_disp != 16'h0 |-> ev_cnt < 4'd8)
		else $error("first-out set without field event");
	chk_aud_cause: assert property ($rose(audible_out) |-> ev_cnt < 4'd8)
		else $error("audible raised without cause");
endmodule // aas_seq_monitor
bind aas_sequencer aas_seq_monitor #(.NCH(NCH)) u_mon (.clk_sys, .rst_n, .clk_en,
	.alarm_lo_in, .alarm_hi_in, .trip_lo_in, .trip_hi_in, .raw_reading, .reset_in,
	.local_in, .remote_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.audible_out, .group_realarm_out, .first_out_disp);
`default_nettype wire

// ===== verification/aas_sequencer_tb.sv
// Self-checking bench for aas_sequencer with a small reference model.
// Assumes aas_defs.vh on the include path and a shortened second.
`timescale 1ns/1ps
`default_nettype none
`include "aas_defs.vh"
module aas_sequencer_tb;
	localparam SEC = 100;
	logic         clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, clk_en = 1;
	logic         ack_in = 0, reset_in = 0, local_in = 0, remote_in = 0;
	logic [15:0]  alarm_lo_in = 0, alarm_hi_in = 0, trip_lo_in = 0, trip_hi_in = 0;
	logic [7:0]   reg_addr = 0;
	logic [31:0]  reg_wdata = 0, reg_rdata, rd, txt, seed = 32'd80268;
	logic [15:0]  lamp_out, first_out_disp, contact_type, l0;
	logic         audible_out, group_realarm_out, minute_sync_in, bus_sync_in;
	logic [159:0] raw_reading;
	logic [255:0] scaled_reading;
	logic [7:0]   code [4] = '{`AAS_FO_LO, `AAS_FO_HI, `AAS_FO_LOLO, `AAS_FO_HIHI};
	int           err_total = 0, n_tests = 0, cyc = 0;
	int           raw_m [16];
	int           pat_m, site_m, c, nt, na, s0, m0;
	aas_field_model #(.HOLD(SEC / 10)) fm (.clk_sys, .raw_reading, .scaled_reading,
		.contact_type, .minute_sync_in, .bus_sync_in);
	aas_sequencer #(.NCH(16), .SEC_CYCLES(SEC)) dut (.clk_sys, .rst_n, .clk_en,
		.alarm_lo_in, .alarm_hi_in, .trip_lo_in, .trip_hi_in, .contact_type, .raw_reading,
		.scaled_reading, .ack_in, .reset_in, .local_in, .remote_in, .minute_sync_in,
		.bus_sync_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .lamp_out,
		.audible_out, .group_realarm_out, .first_out_disp);
	always #5 clk_sys = ~clk_sys;
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task end_sim();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// A hang here would otherwise stall the run silently
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 9000) begin
			err_total++;
			end_sim();
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys) reg_wr <= 1'b0;
	endtask
	task rdr(input logic [7:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys) reg_rd <= 1'b0;
		@(negedge clk_sys) rd = reg_rdata;
	endtask
	task chr(input logic [7:0] a, input logic [31:0] e, input string nm);
		rdr(a);
		chk(nm, e, rd);
	endtask
	task set_in(input int t, input int ch, input logic v);
		@(posedge clk_sys);
		case (t)
			0: alarm_lo_in[ch] <= v;
			1: alarm_hi_in[ch] <= v;
			2: trip_lo_in[ch] <= v;
			default: trip_hi_in[ch] <= v;
		endcase
	endtask
	task settle(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		chr(8'h01, `AAS_SITE_RST, "site_rst");
		wr(8'h02, 32'h3);
		for (int p = 0; p < 6; p++) begin
			wr(8'h00, p);
			if (p < 5) pat_m = p;
			chr(8'h00, pat_m, "pattern");
		end
		for (int s = 3; s >= 0; s--) begin
			wr(8'h01, s);
			if (s > 0) site_m = s;
			chr(8'h01, site_m, "site");
		end
		chr(8'h08, 0, "unmapped");
		wr(8'h11, 2);
		wr(8'h11, 3);
		chr(8'h11, 2, "chmode");
		for (int i = 0; i < 16; i++) begin
			raw_m[i] = rnd() & 32'h3ff;
			fm.set_raw(i, raw_m[i]);
		end
		for (int i = 0; i < 16; i++) chr(8'h20 + i, raw_m[i], "raw");
		for (int w = 0; w < 3; w++) begin
			txt = rnd() & (w == 2 ? 32'hffff : 32'hffffffff);
			wr(8'h54 + w, txt);
			chr(8'h54 + w, txt, "text");
		end
		wr(8'h00, `AAS_PAT_MANUAL);
		for (int t = 0; t < 4; t++) begin
			c = 1 + rnd() % 8;
			set_in(t, c, 1'b1);
			settle(8);
			set_in((t + 1) % 4, 0, 1'b1);
			settle(8);
			chk("fo_disp", {code[t], 8'(c + 1)}, first_out_disp);
			chr(8'h03, {15'h0, 1'b1, code[t], 8'(c + 1)}, "fo_reg");
			set_in(t, c, 1'b0);
			set_in((t + 1) % 4, 0, 1'b0);
			if (t % 2) begin
				@(posedge clk_sys) reset_in <= 1'b1;
				@(posedge clk_sys) reset_in <= 1'b0;
			end else wr(8'h07, 32'h2);
			settle(8);
			chk("fo_clear", 0, first_out_disp);
		end
		wr(8'h07, 32'h1);
		settle(4);
		chk("quiet", 0, {audible_out, group_realarm_out});
		set_in(0, 3, 1'b1);
		settle(8);
		chk("audible", 1, audible_out);
		chk("realarm", 1, group_realarm_out);
		chr(8'h33, 1, "contact_closed");
		chr(8'h34, 0, "contact_open");
		chr(8'h38, raw_m[8], "scaled");
		@(posedge clk_sys) remote_in <= 1'b1;
		settle(8);
		chk("mute", 0, audible_out);
		@(posedge clk_sys) remote_in <= 1'b0;
		local_in <= 1'b1;
		settle(8);
		chk("block", 0, group_realarm_out);
		@(posedge clk_sys) local_in <= 1'b0;
		wr(8'h01, `AAS_SITE_UNMAN);
		settle(8);
		chk("site_unman", 0, audible_out);
		wr(8'h01, `AAS_SITE_INPUTS);
		@(posedge clk_sys) ack_in <= 1'b1;
		@(posedge clk_sys) ack_in <= 1'b0;
		settle(8);
		chk("ack", 0, audible_out);
		set_in(0, 3, 1'b0);
		wr(8'h07, 32'h3);
		wr(8'h12, `AAS_CM_STEADY);
		set_in(1, 2, 1'b1);
		settle(8);
		repeat (16) begin
			chk("steady", 1, {audible_out, lamp_out[2]});
			@(negedge clk_sys);
		end
		set_in(1, 2, 1'b0);
		settle(8);
		chk("steady_off", 0, lamp_out[2]);
		set_in(3, 4, 1'b1);
		set_in(0, 5, 1'b1);
		settle(8);
		nt = 0;
		na = 0;
		repeat (64) begin
			l0 = lamp_out;
			@(negedge clk_sys);
			nt += l0[4] != lamp_out[4];
			na += l0[5] != lamp_out[5];
		end
		chk("trip_flash", 16, nt);
		chk("alarm_flash", 8, na);
		// A low clock enable must stop the divider and every lamp
		@(posedge clk_sys) clk_en <= 1'b0;
		settle(0);
		l0 = lamp_out;
		settle(4);
		chk("freeze", l0, lamp_out);
		@(posedge clk_sys) clk_en <= 1'b1;
		set_in(3, 4, 1'b0);
		set_in(0, 5, 1'b0);
		wr(8'h07, 32'h3);
		wr(8'h00, `AAS_PAT_RING);
		wr(8'h16, `AAS_CM_RINGAUD);
		set_in(0, 6, 1'b1);
		settle(8);
		wr(8'h07, 32'h1);
		set_in(0, 6, 1'b0);
		settle(8);
		chk("ringback", 1, audible_out);
		wr(8'h07, 32'h3);
		settle(4);
		chk("ring_clr", 0, {audible_out, lamp_out[6]});
		// Align the second first, so that exactly one tick falls between the reads
		for (int k = 0; k < 2; k++) begin
			if (k) wr(8'h07, 32'h4);
			else fm.sync_pulse(1'b0);
			rdr(8'h06);
			s0 = rd[5:0];
			repeat (SEC - 3) @(posedge clk_sys);
			chr(8'h06, rd + ((s0 + 1) % 60) - s0, "second");
		end
		for (int up = 1; up >= 0; up--) begin
			do begin
				repeat (SEC) @(posedge clk_sys);
				rdr(8'h06);
			end while ((rd[5:0] >= 30) != up);
			m0 = rd[13:8];
			fm.sync_pulse(1'b1);
			rdr(8'h06);
			chk("min_sync", ((m0 + up) % 60) * 256, rd[13:0]);
		end
		end_sim();
	end
endmodule // aas_sequencer_tb
`default_nettype wire
